/* common/ssr_defines.vh */
// constants of the sample rate reducer
// Operation
// - two 14-bit channels, kept separate per channel
// - one converter sample per channel each period
// - group of N samples gives one record
// - averaging or decimation selects group result
// - min/max: min and max of 2N samples
// - min/max pairs come at half rate
// - buffer 8k per channel, 16k build option
// - real-time trigger, several sources, trigger output
// - edge, pulse, transition trigger with hysteresis
// - mixed mode shares one sample timing tick
// - full buffer before upload, then rearm allowed
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH
`define SSR_SMP_W        14
`define SSR_DIV_W        16
`define SSR_SUM_W        30
`define SSR_MEM_W        28
`define SSR_AW_STD       13
`define SSR_AW_BIG       14
// reduction modes
`define SSR_MODE_AVG     2'h0
`define SSR_MODE_DEC     2'h1
`define SSR_MODE_MINMAX  2'h2
// trigger kinds
`define SSR_TRIG_EDGE    2'h0
`define SSR_TRIG_PULSE   2'h1
`define SSR_TRIG_TRANS   2'h2
// trigger sources
`define SSR_SRC_OWN      2'h0
`define SSR_SRC_INST     2'h1
`define SSR_SRC_EXT      2'h2
`define SSR_SRC_NOW      2'h3
`endif

/* hdl/ssr_mem.v */
// simple dual-port acquisition memory with registered read
module ssr_mem #(
   parameter AW = 13,
   parameter DW = 28
) (
   input  wire          i_core_clk,
   input  wire          i_wen,
   input  wire [AW-1:0] i_waddr,
   input  wire [DW-1:0] i_wdata,
   input  wire          i_ren,
   input  wire [AW-1:0] i_raddr,
   output reg  [DW-1:0] o_rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // write port and registered read port
   always @(posedge i_core_clk) begin
      if (i_wen) begin
         mem[i_waddr] <= i_wdata;
      end
      if (i_ren) begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule // ssr_mem

/* hdl/ssr_top.v */
// sample rate reducer: reduction, trigger, capture buffer and upload
`include "ssr_defines.vh"
module ssr_top #(
   parameter P_BIG_BUF = 0
) (
   input  wire                     i_core_clk,
   input  wire                     i_resetn,
   input  wire [`SSR_SMP_W-1:0]    i_adc_ch0,
   input  wire [`SSR_SMP_W-1:0]    i_adc_ch1,
   input  wire                     i_adc_toggle,
   input  wire [1:0]               i_mode,
   input  wire [`SSR_DIV_W-1:0]    i_div_n,
   input  wire                     i_arm,
   input  wire [1:0]               i_trig_src,
   input  wire [1:0]               i_trig_kind,
   input  wire                     i_trig_chan,
   input  wire                     i_trig_fall,
   input  wire [`SSR_SMP_W-1:0]    i_trig_level,
   input  wire [`SSR_SMP_W-2:0]    i_trig_hyst,
   input  wire [`SSR_DIV_W-1:0]    i_trig_width,
   input  wire                     i_inst_trig,
   input  wire                     i_ext_trig,
   input  wire                     i_mixed_mode,
   output reg                      o_trig_out,
   output reg                      o_dig_rec_en,
   output wire                     o_busy,
   output reg                      o_upload_done,
   output wire [`SSR_SMP_W-1:0]    o_up_ch0,
   output wire [`SSR_SMP_W-1:0]    o_up_ch1,
   output wire                     o_up_valid,
   input  wire                     i_up_ready
);
   localparam AW = (P_BIG_BUF != 0) ? `SSR_AW_BIG : `SSR_AW_STD;
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_WAIT = 5'h02;
   localparam [4:0] ST_CAPT = 5'h04;
   localparam [4:0] ST_UPLD = 5'h08;
   localparam [4:0] ST_DONE = 5'h10;
   localparam [AW-1:0] ADDR_LAST = {AW{1'b1}};

   // signed average, quotient truncated toward zero
   function [`SSR_SMP_W-1:0] ssr_avg;
      input signed [`SSR_SUM_W-1:0] sum;
      input        [`SSR_DIV_W-1:0] n;
      reg   signed [`SSR_SUM_W-1:0] q;
      begin
         q = sum / $signed({{(`SSR_SUM_W-`SSR_DIV_W){1'b0}}, n});
         ssr_avg = q[`SSR_SMP_W-1:0];
      end
   endfunction

   // two-flop synchronisers for converter pins
   reg [`SSR_SMP_W-1:0] c0_s1_r, c0_s2_r, c1_s1_r, c1_s2_r;
   reg                  tg_s1_r, tg_s2_r, tg_s3_r;
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         c0_s1_r <= 14'h0000;
         c0_s2_r <= 14'h0000;
         c1_s1_r <= 14'h0000;
         c1_s2_r <= 14'h0000;
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_s3_r <= 1'b0;
      end else begin
         c0_s1_r <= i_adc_ch0;
         c0_s2_r <= c0_s1_r;
         c1_s1_r <= i_adc_ch1;
         c1_s2_r <= c1_s1_r;
         tg_s1_r <= i_adc_toggle;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
      end
   end
   wire smp_en = tg_s2_r ^ tg_s3_r;
   wire signed [`SSR_SMP_W-1:0] s0 = c0_s2_r;
   wire signed [`SSR_SMP_W-1:0] s1 = c1_s2_r;

   // group length: N samples, 2N in min/max, N of zero read as one
   wire [`SSR_DIV_W-1:0] n_eff = (i_div_n == 16'h0000) ? 16'h0001 : i_div_n;
   wire                  mm    = (i_mode == `SSR_MODE_MINMAX);
   wire [`SSR_DIV_W:0]   g_last = mm ? {n_eff, 1'b0} - 17'h00001 : {1'b0, n_eff} - 17'h00001;
   reg  [`SSR_DIV_W:0]   g_cnt_r;
   wire                  g_end = (g_cnt_r == g_last);

   // per-channel accumulators, kept apart
   reg signed [`SSR_SUM_W-1:0] sum0_r, sum1_r;
   reg signed [`SSR_SMP_W-1:0] mn0_r, mx0_r, mn1_r, mx1_r;
   wire signed [`SSR_SUM_W-1:0] sum0_nxt = sum0_r + {{(`SSR_SUM_W-`SSR_SMP_W){s0[13]}}, s0};
   wire signed [`SSR_SUM_W-1:0] sum1_nxt = sum1_r + {{(`SSR_SUM_W-`SSR_SMP_W){s1[13]}}, s1};
   wire first = (g_cnt_r == 17'h00000);
   wire signed [`SSR_SMP_W-1:0] mn0_nxt = (first || s0 < mn0_r) ? s0 : mn0_r;
   wire signed [`SSR_SMP_W-1:0] mx0_nxt = (first || s0 > mx0_r) ? s0 : mx0_r;
   wire signed [`SSR_SMP_W-1:0] mn1_nxt = (first || s1 < mn1_r) ? s1 : mn1_r;
   wire signed [`SSR_SMP_W-1:0] mx1_nxt = (first || s1 > mx1_r) ? s1 : mx1_r;

   reg                   rec_vld_r;
   reg [`SSR_MEM_W-1:0]  rec_dat_r;
   reg                   max_pend_r;
   reg [`SSR_MEM_W-1:0]  max_dat_r;

   // group counting and record formation
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         g_cnt_r    <= 17'h00000;
         sum0_r     <= 30'h00000000;
         sum1_r     <= 30'h00000000;
         mn0_r      <= 14'h0000;
         mx0_r      <= 14'h0000;
         mn1_r      <= 14'h0000;
         mx1_r      <= 14'h0000;
         rec_vld_r  <= 1'b0;
         rec_dat_r  <= 28'h0000000;
         max_pend_r <= 1'b0;
         max_dat_r  <= 28'h0000000;
      end else begin
         rec_vld_r <= 1'b0;
         if (max_pend_r) begin
            rec_vld_r  <= 1'b1;
            rec_dat_r  <= max_dat_r;
            max_pend_r <= 1'b0;
         end
         if (smp_en) begin
            if (g_end) begin
               g_cnt_r   <= 17'h00000;
               sum0_r    <= 30'h00000000;
               sum1_r    <= 30'h00000000;
               rec_vld_r <= 1'b1;
               case (i_mode)
                  `SSR_MODE_AVG: begin
                     rec_dat_r <= {ssr_avg(sum1_nxt, n_eff), ssr_avg(sum0_nxt, n_eff)};
                  end
                  `SSR_MODE_DEC: begin
                     rec_dat_r <= {s1, s0};
                  end
                  `SSR_MODE_MINMAX: begin
                     rec_dat_r  <= {mn1_nxt, mn0_nxt};
                     max_dat_r  <= {mx1_nxt, mx0_nxt};
                     max_pend_r <= 1'b1;
                  end
                  default: begin
                     rec_dat_r <= {s1, s0};
                  end
               endcase
            end else begin
               g_cnt_r <= g_cnt_r + 17'h00001;
               sum0_r  <= sum0_nxt;
               sum1_r  <= sum1_nxt;
               mn0_r   <= mn0_nxt;
               mx0_r   <= mx0_nxt;
               mn1_r   <= mn1_nxt;
               mx1_r   <= mx1_nxt;
            end
         end
      end
   end

   // trigger detector on one channel, falling slope by mirroring
   wire signed [`SSR_SMP_W:0] tsel = i_trig_chan ? {s1[13], s1} : {s0[13], s0};
   wire signed [`SSR_SMP_W:0] tlv  = {i_trig_level[13], i_trig_level};
   wire signed [`SSR_SMP_W:0] x    = i_trig_fall ? -tsel : tsel;
   wire signed [`SSR_SMP_W:0] lvl  = i_trig_fall ? -tlv : tlv;
   wire signed [`SSR_SMP_W:0] hys  = {2'b00, i_trig_hyst};
   wire below = (x < lvl - hys);
   wire above = (x > lvl + hys);
   reg        arm_r, run_r;
   reg [`SSR_DIV_W-1:0] wcnt_r;
   reg        own_trig_r;
   wire [`SSR_DIV_W-1:0] wcnt_inc = (wcnt_r == 16'hffff) ? wcnt_r : wcnt_r + 16'h0001;

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         arm_r      <= 1'b0;
         run_r      <= 1'b0;
         wcnt_r     <= 16'h0000;
         own_trig_r <= 1'b0;
      end else begin
         own_trig_r <= 1'b0;
         if (smp_en) begin
            case (i_trig_kind)
               `SSR_TRIG_EDGE: begin
                  run_r <= 1'b0;
                  if (below) begin
                     arm_r <= 1'b1;
                  end else if (arm_r && x >= lvl) begin
                     arm_r      <= 1'b0;
                     own_trig_r <= 1'b1;
                  end
               end
               `SSR_TRIG_PULSE: begin
                  if (below) begin
                     own_trig_r <= run_r && (wcnt_r >= i_trig_width);
                     run_r      <= 1'b0;
                     arm_r      <= 1'b1;
                  end else if (arm_r && x >= lvl) begin
                     arm_r  <= 1'b0;
                     run_r  <= 1'b1;
                     wcnt_r <= 16'h0001;
                  end else if (run_r) begin
                     wcnt_r <= wcnt_inc;
                  end
               end
               `SSR_TRIG_TRANS: begin
                  if (below) begin
                     arm_r <= 1'b1;
                     run_r <= 1'b0;
                  end else if (above && (run_r || arm_r)) begin
                     own_trig_r <= arm_r || (wcnt_r < i_trig_width);
                     run_r      <= 1'b0;
                     arm_r      <= 1'b0;
                  end else if (arm_r) begin
                     arm_r  <= 1'b0;
                     run_r  <= 1'b1;
                     wcnt_r <= 16'h0001;
                  end else if (run_r) begin
                     wcnt_r <= wcnt_inc;
                  end
               end
               default: begin
                  arm_r <= 1'b0;
                  run_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // external trigger pins pass two flops
   reg ext_s1_r, ext_s2_r;
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
      end else begin
         ext_s1_r <= i_ext_trig;
         ext_s2_r <= ext_s1_r;
      end
   end
   reg trig_hit;
   always @* begin
      case (i_trig_src)
         `SSR_SRC_OWN:  trig_hit = own_trig_r;
         `SSR_SRC_INST: trig_hit = i_inst_trig;
         `SSR_SRC_EXT:  trig_hit = ext_s2_r;
         default:       trig_hit = 1'b1;
      endcase
   end

   // acquisition control
   reg [4:0]    st_r;
   reg [AW-1:0] waddr_r, raddr_r;
   reg          rd_more_r, rd_pend_r;
   reg [1:0]    fcnt_r;
   reg [`SSR_MEM_W-1:0] fd0_r, fd1_r;
   wire         wen    = (st_r == ST_CAPT) && rec_vld_r;
   wire         f_pop  = (fcnt_r != 2'h0) && i_up_ready;
   wire [2:0]   f_used = {1'b0, fcnt_r} + {2'b00, rd_pend_r};
   wire         ren    = (st_r == ST_UPLD) && rd_more_r && (f_used < 3'h2);
   wire [`SSR_MEM_W-1:0] rdata;

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r          <= ST_IDLE;
         waddr_r       <= {AW{1'b0}};
         raddr_r       <= {AW{1'b0}};
         rd_more_r     <= 1'b0;
         o_upload_done <= 1'b0;
         o_trig_out    <= 1'b0;
         o_dig_rec_en  <= 1'b0;
      end else begin
         o_upload_done <= 1'b0;
         o_trig_out    <= own_trig_r;
         o_dig_rec_en  <= i_mixed_mode && wen;
         case (st_r)
            ST_IDLE: begin
               if (i_arm) begin
                  st_r    <= ST_WAIT;
                  waddr_r <= {AW{1'b0}};
               end
            end
            ST_WAIT: begin
               if (trig_hit) begin
                  st_r <= ST_CAPT;
               end
            end
            ST_CAPT: begin
               if (wen) begin
                  waddr_r <= waddr_r + {{(AW-1){1'b0}}, 1'b1};
                  if (waddr_r == ADDR_LAST) begin
                     st_r      <= ST_UPLD;
                     raddr_r   <= {AW{1'b0}};
                     rd_more_r <= 1'b1;
                  end
               end
            end
            ST_UPLD: begin
               if (ren) begin
                  raddr_r <= raddr_r + {{(AW-1){1'b0}}, 1'b1};
                  if (raddr_r == ADDR_LAST) begin
                     rd_more_r <= 1'b0;
                  end
               end
               if (!rd_more_r && !rd_pend_r && fcnt_r == 2'h0) begin
                  st_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               o_upload_done <= 1'b1;
               st_r          <= ST_IDLE;
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end
   assign o_busy = (st_r != ST_IDLE);

   ssr_mem #(
      .AW (AW),
      .DW (`SSR_MEM_W)
   ) u_mem (
      .i_core_clk (i_core_clk),
      .i_wen      (wen),
      .i_waddr    (waddr_r),
      .i_wdata    (rec_dat_r),
      .i_ren      (ren),
      .i_raddr    (raddr_r),
      .o_rdata    (rdata)
   );

   // two-entry upload buffer, reads stall while it is full
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_pend_r <= 1'b0;
         fcnt_r    <= 2'h0;
         fd0_r     <= 28'h0000000;
         fd1_r     <= 28'h0000000;
      end else begin
         rd_pend_r <= ren;
         if (f_pop) begin
            fd0_r <= fd1_r;
         end
         if (rd_pend_r) begin
            if (fcnt_r == 2'h0 || (fcnt_r == 2'h1 && f_pop)) begin
               fd0_r <= rdata;
            end else begin
               fd1_r <= rdata;
            end
         end
         fcnt_r <= fcnt_r + {1'b0, rd_pend_r} - {1'b0, f_pop};
      end
   end
   assign o_up_valid = (fcnt_r != 2'h0);
   assign o_up_ch0   = fd0_r[`SSR_SMP_W-1:0];
   assign o_up_ch1   = fd0_r[`SSR_MEM_W-1:`SSR_SMP_W];
endmodule // ssr_top

/* verification/ssr_top_assertions.sv */
// concurrent checks at the ports of the sample rate reducer
`include "ssr_defines.vh"
module ssr_top_assertions (
   input wire                  i_core_clk,
   input wire                  i_resetn,
   input wire [1:0]            i_mode,
   input wire                  i_arm,
   input wire                  i_mixed_mode,
   input wire                  i_up_ready,
   input wire                  o_trig_out,
   input wire                  o_dig_rec_en,
   input wire                  o_busy,
   input wire [`SSR_SMP_W-1:0] o_up_ch0,
   input wire [`SSR_SMP_W-1:0] o_up_ch1,
   input wire                  o_up_valid
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);
   // trigger output is a single-cycle pulse
   a_trig_single: assert property (o_trig_out |=> !o_trig_out)
      else $error("trigger output longer than one cycle");
   // a stalled word stays put until taken
   a_word_hold: assert property (o_up_valid && !i_up_ready |=> o_up_valid && $stable(o_up_ch0) && $stable(o_up_ch1))
      else $error("upload word changed while stalled");
   // idle means nothing left to upload
   a_idle_empty: assert property (!o_busy |-> !o_up_valid)
      else $error("upload word offered while idle");
   // capture is complete before upload
   a_capture_first: assert property (o_up_valid |-> !o_dig_rec_en)
      else $error("entry recorded during upload");
   // entries only while an acquisition runs
   a_rec_busy: assert property (o_dig_rec_en |-> o_busy)
      else $error("entry recorded while idle");
   // shared tick only in mixed operation
   a_rec_mixed: assert property (!$past(i_mixed_mode) |-> !o_dig_rec_en)
      else $error("digital record tick outside mixed mode");
   // arm in idle starts acquisition
   a_arm_start: assert property (!o_busy && i_arm |=> o_busy)
      else $error("arm did not start acquisition");
   // min/max entries come in pairs, never three in a row
   a_minmax_rate: assert property ((i_mode == `SSR_MODE_MINMAX && o_dig_rec_en) [*2] |=> !o_dig_rec_en)
      else $error("min/max entries not paired");
   c_trigger: cover property (o_trig_out);
   c_minmax_pair: cover property (i_mode == `SSR_MODE_MINMAX && o_dig_rec_en ##1 o_dig_rec_en);
   c_stall: cover property (o_up_valid && !i_up_ready);
endmodule  // ssr_top_assertions

bind ssr_top ssr_top_assertions u_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_mode(i_mode),
   .i_arm(i_arm), .i_mixed_mode(i_mixed_mode), .i_up_ready(i_up_ready), .o_trig_out(o_trig_out),
   .o_dig_rec_en(o_dig_rec_en), .o_busy(o_busy), .o_up_ch0(o_up_ch0), .o_up_ch1(o_up_ch1),
   .o_up_valid(o_up_valid));

/* verification/ssr_adc_model.sv */
// converter model: each channel alternates between two words
module ssr_adc_model (
   input  wire         i_core_clk,
   input  wire  [13:0] i_a0,
   input  wire  [13:0] i_b0,
   input  wire  [13:0] i_a1,
   input  wire  [13:0] i_b1,
   output logic [13:0] o_ch0,
   output logic [13:0] o_ch1,
   output logic        o_toggle
);
   timeunit 1ns;
   timeprecision 100ps;
   int   phase = 0;
   logic pick = 1'b0;
   initial begin
      o_ch0 = 14'h0000;
      o_ch1 = 14'h0000;
      o_toggle = 1'b0;
   end
   // new pair three cycles before each toggle, held three after
   always @(posedge i_core_clk) begin
      #1;
      phase = (phase == 5) ? 0 : phase + 1;
      if (phase == 0) begin
         pick = !pick;
         o_ch0 = pick ? i_b0 : i_a0;
         o_ch1 = pick ? i_b1 : i_a1;
      end
      if (phase == 3)
         o_toggle = !o_toggle;
   end
endmodule  // ssr_adc_model

/* verification/scope_sample_rate_reducer_test.sv */
// self-checking bench of the sample rate reducer
`include "ssr_defines.vh"
module scope_sample_rate_reducer_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [13:0] pat [0:3] = '{default: 14'h0000};
   logic [13:0] ch0, ch1, up0, up1;
   logic [15:0] div = 16'h0002;
   logic [13:0] lvl = 14'h0000;
   logic [12:0] hyst = 13'h000a;
   logic [1:0]  mode = `SSR_MODE_AVG;
   logic [1:0]  src = `SSR_SRC_OWN;
   logic [1:0]  kind = 2'h3;
   logic        tog, trig, rec, busy, done, valid;
   logic        arm = 1'b0, mixed = 1'b0, ready = 1'b0;
   logic        chan = 1'b0, fall = 1'b0, ext = 1'b0;
   logic [15:0] width = 16'h0001;
   logic [27:0] cap [0:8191];
   int          bad_count = 0, n_tests = 0, rec_cnt = 0, trig_cnt = 0, up_cnt = 0, ph = 0;

   ssr_adc_model adc (.i_core_clk(clk), .i_a0(pat[0]), .i_b0(pat[1]), .i_a1(pat[2]), .i_b1(pat[3]),
      .o_ch0(ch0), .o_ch1(ch1), .o_toggle(tog));
   ssr_top #(.P_BIG_BUF(0)) dut (.i_core_clk(clk), .i_resetn(rstn), .i_adc_ch0(ch0), .i_adc_ch1(ch1),
      .i_adc_toggle(tog), .i_mode(mode), .i_div_n(div), .i_arm(arm), .i_trig_src(src), .i_trig_kind(kind),
      .i_trig_chan(chan), .i_trig_fall(fall), .i_trig_level(lvl), .i_trig_hyst(hyst), .i_trig_width(width),
      .i_inst_trig(1'b0), .i_ext_trig(ext), .i_mixed_mode(mixed), .o_trig_out(trig), .o_dig_rec_en(rec),
      .o_busy(busy), .o_upload_done(done), .o_up_ch0(up0), .o_up_ch1(up1), .o_up_valid(valid),
      .i_up_ready(ready));

   initial forever #4 clk = ~clk;
   // pulse counts and upload capture
   always @(posedge clk) begin
      rec_cnt += (rec === 1'b1);
      trig_cnt += (trig === 1'b1);
      if (valid === 1'b1 && ready === 1'b1 && up_cnt < 8192)
         cap[up_cnt] = {up1, up0};
      up_cnt += (valid === 1'b1 && ready === 1'b1);
   end
   // host stalls one cycle in three, longer every 64
   always @(posedge clk) begin
      #1;
      ph++;
      ready = (ph % 3 != 0) && (ph % 64 > 8);
   end

   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(string what, logic [27:0] seen, logic [27:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic arm_once();
      arm = 1'b1;
      step(1);
      arm = 1'b0;
      chk("busy after arm", busy, 1'b1);
   endtask
   // armed, in-band level then a rise: no trigger, nothing stored
   task automatic t_band_rise();
      mixed = 1'b1;
      kind = `SSR_TRIG_EDGE;
      pat = '{14'h3ffb, 14'h3ffb, 14'h0000, 14'h0000};
      step(30);
      arm_once();
      pat = '{14'h0032, 14'h0032, 14'h0000, 14'h0000};
      step(60);
      chk("no trigger inside band", trig_cnt, 0);
      chk("nothing stored before trigger", rec_cnt, 0);
   endtask
   // below the band, then a rise to the level fires once
   task automatic t_edge_hit();
      int i;
      pat = '{14'h3f9c, 14'h3f9c, 14'h0000, 14'h0000};
      step(30);
      pat = '{14'h0032, 14'h0032, 14'h0000, 14'h0000};
      for (i = 0; i < 60 && trig_cnt == 0; i++)
         step(1);
      pat = '{14'h3ffd, 14'h3ffc, 14'h0064, 14'h0007};
      chk("edge trigger", trig_cnt, 1);
   endtask
   // average, decimate, then min/max, switched on entry counts
   task automatic t_capture();
      int i;
      for (i = 0; i < 30000 && rec_cnt < 2048; i++)
         step(1);
      mode = `SSR_MODE_DEC;
      pat = '{14'h3ffb, 14'h0007, 14'h00c8, 14'h3ff7};
      for (i = 0; i < 15000 && rec_cnt < 3072; i++)
         step(1);
      mode = `SSR_MODE_MINMAX;
      div = 16'h0001;
      pat = '{14'h3ffe, 14'h0006, 14'h03e8, 14'h3c18};
      for (i = 0; i < 60000 && done !== 1'b1; i++)
         step(1);
      chk("upload done pulse", done, 1'b1);
      step(3);
      chk("entries recorded", rec_cnt, 8192);
      chk("words uploaded", up_cnt, 8192);
      chk("idle after upload", busy, 1'b0);
      chk("single trigger", trig_cnt, 1);
   endtask
   // stored words per segment, clear of the mode changes
   task automatic t_contents();
      int          i;
      logic [27:0] d;
      for (i = 4; i < 2044; i++)
         chk("average", cap[i], {14'h0035, 14'h3ffd});
      d = cap[2052];
      chk("decimate pick", d === {14'h00c8, 14'h3ffb} || d === {14'h3ff7, 14'h0007}, 1'b1);
      for (i = 2052; i < 3068; i++)
         chk("decimate", cap[i], d);
      for (i = 3080; i < 8192; i++) begin
         chk("min or max", cap[i] === {14'h3c18, 14'h3ffe} || cap[i] === {14'h03e8, 14'h0006}, 1'b1);
         chk("alternates", cap[i] !== cap[i - 1], 1'b1);
      end
   endtask
   // pulse width on ch1 with falling slope, then capture started by the pin
   task automatic t_more_trig();
      int r0;
      kind = `SSR_TRIG_PULSE;
      chan = 1'b1;
      fall = 1'b1;
      width = 16'h0020;
      pat = '{14'h0000, 14'h0000, 14'h0064, 14'h0064};
      step(30);
      pat = '{14'h0000, 14'h0000, 14'h3fce, 14'h3fce};
      step(60);
      pat = '{14'h0000, 14'h0000, 14'h0064, 14'h0064};
      step(30);
      chk("pulse shorter than width", trig_cnt, 1);
      width = 16'h0003;
      pat = '{14'h0000, 14'h0000, 14'h3fce, 14'h3fce};
      step(60);
      pat = '{14'h0000, 14'h0000, 14'h0064, 14'h0064};
      step(30);
      chk("pulse trigger", trig_cnt, 2);
      kind = 2'h3;
      src = `SSR_SRC_EXT;
      r0 = rec_cnt;
      arm_once();
      step(30);
      chk("nothing stored before pin trigger", rec_cnt, r0);
      ext = 1'b1;
      step(40);
      ext = 1'b0;
      chk("pin trigger starts capture", rec_cnt > r0, 1'b1);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      #1;
      rstn = 1'b1;
      step(2);
      t_band_rise();
      t_edge_hit();
      t_capture();
      t_contents();
      t_more_trig();
      results();
   end
   // watchdog
   initial begin
      #800000;
      bad_count++;
      results();
   end
endmodule  // scope_sample_rate_reducer_test
